// file: logic/bfa_clk_div.sv
// Divider that turns the core clock into a flash-period tick enable
`timescale 1ns/1ps
module bfa_clk_div (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic rstn_i,
	// Rate select
	input wire logic [1:0] sel_i,
	// One-cycle flash period enable
	output logic tick_o
);

	logic [1:0] cnt;
	logic [1:0] next_cnt;

	always_comb begin
		next_cnt = cnt + 2'h1;
		case (sel_i)
			bfa_pkg::CLK_FULL: tick_o = 1'b1; // [RQ4] [RQ5]
			bfa_pkg::CLK_DIV2: tick_o = cnt[0]; // [RQ4] [RQ5]
			// Reserved code runs at the slowest rate, the safe side for the flash
			default: tick_o = (cnt == bfa_pkg::DIV_LAST_DIV4); // [RQ4] [RQ5]
		endcase
	end

	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			cnt <= bfa_pkg::DIV_CNT_RST;
		end else begin
			cnt <= next_cnt;
		end
	end

endmodule : bfa_clk_div

// file: logic/bfa_ctrl.sv
// Asynchronous-mode controller for an external 16-bit burst flash
`timescale 1ns/1ps
module bfa_ctrl #(
	parameter int AVL_W = bfa_pkg::AVL_W,
	parameter int OEL_W = bfa_pkg::OEL_W
) (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic rstn_i,
	// Configuration
	input wire logic [1:0] op_mode_field_i,
	input wire logic [1:0] clock_divider_field_i,
	input wire logic [AVL_W-1:0] addr_valid_latency_i,
	input wire logic [OEL_W-1:0] bus_release_latency_i,
	input wire logic mux_enable_i,
	// Request from on-chip masters
	input wire logic req_valid_i,
	output logic req_ready_o,
	input wire logic req_write_i,
	input wire logic [1:0] req_size_i,
	input wire logic [bfa_pkg::REQ_ADDR_W-1:0] req_addr_i,
	input wire logic [31:0] req_wdata_i,
	// Answer
	output logic resp_valid_o,
	output logic [31:0] resp_rdata_o,
	// Flash pins
	output logic flash_clk_out_o,
	output logic flash_select_n_o,
	output logic addr_valid_n_o,
	output logic addr_advance_n_o,
	output logic out_enable_n_o,
	output logic write_strobe_n_o,
	input wire logic flash_ready_in_i,
	output logic [bfa_pkg::FLASH_ADDR_W-1:0] flash_addr_o,
	output logic [bfa_pkg::FLASH_DATA_W-1:0] flash_data_o,
	output logic flash_data_oe_o,
	input wire logic [bfa_pkg::FLASH_DATA_W-1:0] flash_data_i
);

	////////////////////////////////////////////////////////////////////////////////////////////
	// Parameter checks

	if (AVL_W < 1 || AVL_W > 8 || OEL_W < 1 || OEL_W > 8) begin : g_chk
		$error("bfa_ctrl: latency widths must lie between 1 and 8");
	end

	// The flash address is the request's half-word address, so one more bit is needed
	if (bfa_pkg::REQ_ADDR_W < bfa_pkg::FLASH_ADDR_W + 1) begin : g_chk_addr
		$error("bfa_ctrl: request address too narrow for the flash address bus");
	end

	////////////////////////////////////////////////////////////////////////////////////////////
	// Flash period tick and counters

	logic tick;
	logic phase_load;
	logic [AVL_W-1:0] phase_val;
	logic phase_zero;
	logic rel_load;
	logic rel_zero;

	bfa_clk_div u_div (
		.core_clk_i(core_clk_i),
		.rstn_i(rstn_i),
		.sel_i(clock_divider_field_i),
		.tick_o(tick)
	);

	bfa_tick_cnt #(.W(AVL_W)) u_phase (
		.core_clk_i(core_clk_i),
		.rstn_i(rstn_i),
		.tick_i(tick),
		.load_i(phase_load),
		.load_val_i(phase_val),
		.zero_o(phase_zero)
	);

	bfa_tick_cnt #(.W(OEL_W)) u_release (
		.core_clk_i(core_clk_i),
		.rstn_i(rstn_i),
		.tick_i(tick),
		.load_i(rel_load),
		.load_val_i(bus_release_latency_i),
		.zero_o(rel_zero)
	);

	////////////////////////////////////////////////////////////////////////////////////////////
	// Access sequencer

	bfa_pkg::bfa_state_e state;
	bfa_pkg::bfa_state_e next_state;
	logic is_write;
	logic next_is_write;
	logic [1:0] size;
	logic [1:0] next_size;
	logic second;
	logic next_second;
	logic [bfa_pkg::REQ_ADDR_W-1:0] addr;
	logic [bfa_pkg::REQ_ADDR_W-1:0] next_addr;
	logic [15:0] wdata;
	logic [15:0] next_wdata;
	logic [31:0] rdata;
	logic [31:0] next_rdata;
	logic clk_phase;
	logic next_clk_phase;
	logic [15:0] rd_half;

	assign phase_val = addr_valid_latency_i; // [RQ15]
	assign req_ready_o = (state == bfa_pkg::ST_IDLE) && (op_mode_field_i != bfa_pkg::MODE_OFF); // [RQ1]
	assign resp_valid_o = (state == bfa_pkg::ST_RESP);
	assign resp_rdata_o = rdata;

	////////////////////////////////////////////////////////////////////////////////////////////
	// Read data steering

	// The ready input is not used here: asynchronous cycles are timed by the latency only
	always_comb begin
		rd_half = flash_data_i;
		if (size == bfa_pkg::SIZE_BYTE) begin
			rd_half = {8'h00, addr[0] ? flash_data_i[15:8] : flash_data_i[7:0]}; // [RQ9]
		end
	end

	always_comb begin
		next_state = state;
		next_is_write = is_write;
		next_size = size;
		next_second = second;
		next_addr = addr;
		next_wdata = wdata;
		next_rdata = rdata;
		phase_load = 1'b0;
		rel_load = 1'b0;
		case (state)
			bfa_pkg::ST_IDLE: begin
				if (req_valid_i && req_ready_o) begin
					next_is_write = req_write_i;
					next_size = req_size_i;
					next_second = 1'b0;
					next_addr = req_addr_i;
					next_wdata = req_wdata_i[15:0];
					next_rdata = 32'h0000_0000;
					if (op_mode_field_i != bfa_pkg::MODE_ASYNC) begin
						// Burst and reserved codes answer at once without any cycle
						next_state = bfa_pkg::ST_RESP; // [RQ2] [RQ3]
					end else if (req_write_i && req_size_i != bfa_pkg::SIZE_HALF) begin
						next_state = bfa_pkg::ST_RESP; // [RQ10]
					end else begin
						next_state = bfa_pkg::ST_WAIT;
					end
				end
			end
			bfa_pkg::ST_WAIT: begin
				// Separate buses skip the release wait and only wait for a tick; the flash drives only data pins
				if (tick && !(mux_enable_i && !rel_zero)) begin // [RQ19] [RQ20] [RQ21]
					next_state = bfa_pkg::ST_ADDR;
					phase_load = 1'b1; // [RQ15]
				end
			end
			bfa_pkg::ST_ADDR: begin
				if (tick && phase_zero) begin
					phase_load = 1'b1; // [RQ15]
					next_state = is_write ? bfa_pkg::ST_STRB : bfa_pkg::ST_TURN; // [RQ13] [RQ14]
				end
			end
			bfa_pkg::ST_TURN: begin
				if (tick) begin
					phase_load = 1'b1;
					next_state = bfa_pkg::ST_STRB; // [RQ14]
				end
			end
			bfa_pkg::ST_STRB: begin
				if (tick && phase_zero) begin
					if (is_write) begin
						next_state = bfa_pkg::ST_HOLD; // [RQ17]
					end else begin
						rel_load = 1'b1; // [RQ18]
						if (second) begin
							next_rdata = {rd_half, rdata[15:0]}; // [RQ9]
						end else begin
							next_rdata = {16'h0000, rd_half};
						end
						if (size == bfa_pkg::SIZE_WORD && !second) begin
							next_second = 1'b1; // [RQ9]
							next_addr = addr + bfa_pkg::REQ_ADDR_W'(2);
							next_state = bfa_pkg::ST_WAIT;
						end else begin
							next_state = bfa_pkg::ST_RESP; // [RQ16]
						end
					end
				end
			end
			bfa_pkg::ST_HOLD: begin
				if (tick) begin
					next_state = bfa_pkg::ST_RESP; // [RQ17]
				end
			end
			bfa_pkg::ST_RESP: begin
				next_state = bfa_pkg::ST_IDLE;
			end
			default: begin
				next_state = bfa_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			state <= bfa_pkg::ST_IDLE; // [RQ1]
			is_write <= 1'b0;
			size <= bfa_pkg::SIZE_BYTE;
			second <= 1'b0;
			addr <= '0;
			wdata <= 16'h0000;
			rdata <= 32'h0000_0000;
		end else begin
			state <= next_state;
			is_write <= next_is_write;
			size <= next_size;
			second <= next_second;
			addr <= next_addr;
			wdata <= next_wdata;
			rdata <= next_rdata;
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////////
	// Pin drivers, registered from the next state so strobes and select change on tick edges

	logic next_cs_n;
	logic next_avd_n;
	logic next_oe_n;
	logic next_we_n;
	logic next_doe;
	logic [15:0] next_dout;
	logic [bfa_pkg::FLASH_ADDR_W-1:0] next_aout;

	always_comb begin
		next_cs_n = !(next_state inside {bfa_pkg::ST_ADDR, bfa_pkg::ST_TURN,
			bfa_pkg::ST_STRB, bfa_pkg::ST_HOLD}); // [RQ22] [RQ25]
		next_avd_n = (next_state != bfa_pkg::ST_ADDR); // [RQ11] [RQ23]
		next_oe_n = !(next_state == bfa_pkg::ST_STRB && !next_is_write); // [RQ14] [RQ16]
		next_we_n = !(next_state == bfa_pkg::ST_STRB && next_is_write); // [RQ13]
		next_aout = next_addr[bfa_pkg::FLASH_ADDR_W:1]; // [RQ11] [RQ23]
		next_doe = 1'b0;
		next_dout = 16'h0000;
		if (next_state == bfa_pkg::ST_ADDR && mux_enable_i) begin
			next_doe = 1'b1; // [RQ12]
			next_dout = next_addr[16:1]; // [RQ12]
		end else if (next_is_write && (next_state inside {bfa_pkg::ST_STRB,
			bfa_pkg::ST_HOLD})) begin
			next_doe = 1'b1; // [RQ17]
			next_dout = next_wdata;
		end
		// Only a burst clock toggles; at full rate it runs at half speed, a known limitation
		case (op_mode_field_i)
			bfa_pkg::MODE_BURST: begin
				if (tick) begin
					next_clk_phase = !clk_phase;
				end else begin
					next_clk_phase = clk_phase;
				end
			end
			default: begin
				// Disabled, asynchronous and reserved codes keep the pin low
				next_clk_phase = 1'b0; // [RQ8]
			end
		endcase
	end

	assign flash_clk_out_o = clk_phase;
	assign addr_advance_n_o = 1'b1; // [RQ23]

	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			flash_select_n_o <= 1'b1;
			addr_valid_n_o <= 1'b1;
			out_enable_n_o <= 1'b1;
			write_strobe_n_o <= 1'b1;
			flash_addr_o <= '0;
			flash_data_o <= 16'h0000;
			flash_data_oe_o <= 1'b0;
			clk_phase <= 1'b0;
		end else begin
			flash_select_n_o <= next_cs_n;
			addr_valid_n_o <= next_avd_n;
			out_enable_n_o <= next_oe_n;
			write_strobe_n_o <= next_we_n;
			flash_addr_o <= next_aout;
			flash_data_o <= next_dout;
			flash_data_oe_o <= next_doe;
			clk_phase <= next_clk_phase;
		end
	end

endmodule : bfa_ctrl

// file: logic/bfa_pkg.sv
// Constants, codes and state encoding for the asynchronous flash controller
// What this block does
// [RQ1] After reset nothing runs until the mode input leaves disabled.
// [RQ2] Once enabled from reset, accesses run in asynchronous read/program mode.
// [RQ3] Mode code 0 disabled, 1 asynchronous, 2 burst read, 3 reserved.
// [RQ4] Flash timing rate is core clock, core clock over 2, or over 4.
// [RQ5] Clock code 1 full rate, 2 divide by 2, 3 divide by 4; 0 reserved.
// [RQ6] All latencies and pin timing count in selected flash clock periods.
// [RQ7] Software must set the clock code even for asynchronous operation.
// [RQ8] In asynchronous mode the flash clock pin is held low.
// [RQ9] Byte, half and word reads served; a word becomes two half reads.
// [RQ10] Only half-word writes reach the flash; others are dropped silently.
// [RQ11] Every access drives the address while pulsing address valid low.
// [RQ12] Multiplexed option also drives the address on the data bus.
// [RQ13] Write strobe asserts in the flash cycle after the address phase.
// [RQ14] Read output enable asserts one extra cycle later for bus turnaround.
// [RQ15] Address valid and strobe pulses last latency field plus one.
// [RQ16] A read ends at the rising edge of output enable.
// [RQ17] Write data and address stay driven briefly after the strobe rises.
// [RQ18] After a read the data bus stays unused for the release latency.
// [RQ19] Multiplexed bus: release latency idle cycles before a following access.
// [RQ20] Separate buses: a write may follow a read with no idle cycles.
// [RQ21] Release latency adds no delay to a read following a write.
// [RQ22] When enabled the block drives address, data and chip select.
// [RQ23] Strobes and select active low, ready active high; 25-bit address.
// [RQ24] Software routes the shared pins to this block before use.
// [RQ25] Chip select low from address phase until strobe ends, high between; the code keeps it low one more flash period after a write strobe.
package bfa_pkg;

	localparam logic [1:0] MODE_OFF = 2'h0;
	localparam logic [1:0] MODE_ASYNC = 2'h1;
	localparam logic [1:0] MODE_BURST = 2'h2;

	localparam logic [1:0] CLK_FULL = 2'h1;
	localparam logic [1:0] CLK_DIV2 = 2'h2;
	localparam logic [1:0] CLK_DIV4 = 2'h3;

	localparam logic [1:0] SIZE_BYTE = 2'h0;
	localparam logic [1:0] SIZE_HALF = 2'h1;
	localparam logic [1:0] SIZE_WORD = 2'h2;

	localparam int FLASH_ADDR_W = 25;
	localparam int FLASH_DATA_W = 16;
	localparam int REQ_ADDR_W = 28;
	localparam int AVL_W = 4;
	localparam int OEL_W = 2;

	localparam logic [1:0] DIV_CNT_RST = 2'h0;
	localparam logic [1:0] DIV_LAST_DIV4 = 2'h3;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_WAIT = 3'b001,
		ST_ADDR = 3'b010,
		ST_TURN = 3'b011,
		ST_STRB = 3'b100,
		ST_HOLD = 3'b101,
		ST_RESP = 3'b110
	} bfa_state_e;

endpackage : bfa_pkg

// file: logic/bfa_tick_cnt.sv
// Loadable down counter that steps once per flash period
`timescale 1ns/1ps
module bfa_tick_cnt #(
	parameter int W = 4
) (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic rstn_i,
	// Control
	input wire logic tick_i,
	input wire logic load_i,
	input wire logic [W-1:0] load_val_i,
	// State
	output logic zero_o
);

	logic [W-1:0] count;
	logic [W-1:0] next_count;

	if (W < 1) begin : g_chk
		$error("bfa_tick_cnt: W must be at least 1");
	end

	always_comb begin
		next_count = count;
		if (load_i) begin
			next_count = load_val_i;
		end else if (tick_i && (count != '0)) begin
			next_count = count - W'(1); // [RQ6]
		end
	end

	assign zero_o = (count == '0);

	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			count <= '0;
		end else begin
			count <= next_count;
		end
	end

endmodule : bfa_tick_cnt

// file: sim/bfa_ctrl_asserts.sv
// Port checker for the asynchronous flash controller
`timescale 1ns/1ps
module bfa_ctrl_asserts #(
	parameter int AVL_W = 4,
	parameter int OEL_W = 2
) (
	// Clock, reset and configuration
	input wire logic core_clk_i,
	input wire logic rstn_i,
	input wire logic [1:0] op_mode_field_i,
	input wire logic [1:0] clock_divider_field_i,
	input wire logic [AVL_W-1:0] addr_valid_latency_i,
	input wire logic mux_enable_i,
	// Request side
	input wire logic req_ready_o,
	input wire logic resp_valid_o,
	// Flash pins
	input wire logic flash_clk_out_o,
	input wire logic flash_select_n_o,
	input wire logic addr_valid_n_o,
	input wire logic addr_advance_n_o,
	input wire logic out_enable_n_o,
	input wire logic write_strobe_n_o,
	input wire logic [bfa_pkg::FLASH_ADDR_W-1:0] flash_addr_o,
	input wire logic [bfa_pkg::FLASH_DATA_W-1:0] flash_data_o,
	input wire logic flash_data_oe_o
);
////////////////////////////////////////
	logic [7:0] avd_cnt;
	logic [7:0] oe_cnt;
	logic [7:0] we_cnt;
	logic [7:0] want;
	logic [1:0] sh;
	// Reserved divider code runs at the slowest rate
	assign sh = (clock_divider_field_i == 2'h1) ? 2'h0 :
		(clock_divider_field_i == 2'h2) ? 2'h1 : 2'h2;
	assign want = (8'(addr_valid_latency_i) + 8'h01) << sh;
	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			avd_cnt <= 8'h00;
			oe_cnt <= 8'h00;
			we_cnt <= 8'h00;
		end else begin
			avd_cnt <= addr_valid_n_o ? 8'h00 : avd_cnt + 8'h01;
			oe_cnt <= out_enable_n_o ? 8'h00 : oe_cnt + 8'h01;
			we_cnt <= write_strobe_n_o ? 8'h00 : we_cnt + 8'h01;
		end
	end
////////////////////////////////////////
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rstn_i);
	a_off_no_ready: assert property (op_mode_field_i == 2'h0 |-> !req_ready_o)
		else $error("ready while disabled");
	a_off_no_select: assert property ((op_mode_field_i == 2'h0) [*2] |-> flash_select_n_o)
		else $error("select while disabled");
	a_async_clk_low: assert property ((op_mode_field_i == 2'h1) [*2] |-> !flash_clk_out_o)
		else $error("flash clock moves in async mode");
	a_avd_width: assert property ($rose(addr_valid_n_o) |-> avd_cnt == want)
		else $error("address valid width");
	a_oe_width: assert property ($rose(out_enable_n_o) |-> oe_cnt == want)
		else $error("output enable width");
	a_we_width: assert property ($rose(write_strobe_n_o) |-> we_cnt == want)
		else $error("write strobe width");
	a_we_after_avd: assert property ($fell(write_strobe_n_o) |-> $rose(addr_valid_n_o))
		else $error("write strobe not after address phase");
	a_strobe_select: assert property (!(addr_valid_n_o && out_enable_n_o && write_strobe_n_o)
		|-> !flash_select_n_o) else $error("strobe without select");
	a_oe_no_drive: assert property (!out_enable_n_o |-> !flash_data_oe_o && write_strobe_n_o)
		else $error("bus driven during read");
	a_we_hold: assert property ($rose(write_strobe_n_o) |-> flash_data_oe_o)
		else $error("write data released early");
	a_mux_addr: assert property (!addr_valid_n_o && mux_enable_i |-> flash_data_oe_o
		&& flash_data_o == flash_addr_o[15:0]) else $error("address missing on data bus");
	a_adv_idle: assert property (addr_advance_n_o)
		else $error("address advance asserted");
	a_we_addr_hold: assert property ($rose(write_strobe_n_o) |-> $stable(flash_addr_o))
		else $error("write address released early");
	c_resp: cover property (resp_valid_o);
	c_mux: cover property (!addr_valid_n_o && mux_enable_i);
	c_write: cover property ($fell(write_strobe_n_o));
	c_read: cover property ($fell(out_enable_n_o));
endmodule : bfa_ctrl_asserts

bind bfa_ctrl bfa_ctrl_asserts #(.AVL_W(AVL_W), .OEL_W(OEL_W)) bfa_ctrl_asserts_i (
	.core_clk_i(core_clk_i),
	.rstn_i(rstn_i),
	.op_mode_field_i(op_mode_field_i),
	.clock_divider_field_i(clock_divider_field_i),
	.addr_valid_latency_i(addr_valid_latency_i),
	.mux_enable_i(mux_enable_i),
	.req_ready_o(req_ready_o),
	.resp_valid_o(resp_valid_o),
	.flash_clk_out_o(flash_clk_out_o),
	.flash_select_n_o(flash_select_n_o),
	.addr_valid_n_o(addr_valid_n_o),
	.addr_advance_n_o(addr_advance_n_o),
	.out_enable_n_o(out_enable_n_o),
	.write_strobe_n_o(write_strobe_n_o),
	.flash_addr_o(flash_addr_o),
	.flash_data_o(flash_data_o),
	.flash_data_oe_o(flash_data_oe_o)
);

// file: sim/bfa_ctrl_tb_top.sv
// Self-checking bench for the asynchronous flash controller
`timescale 1ns/1ps
module bfa_ctrl_tb_top;
	logic core_clk_i = 1'b0;
	logic rstn_i = 1'b0;
	logic [1:0] op_mode_field_i = 2'h0;
	logic [1:0] clock_divider_field_i = 2'h1;
	logic [3:0] addr_valid_latency_i = 4'h1;
	logic [1:0] bus_release_latency_i = 2'h1;
	logic mux_enable_i = 1'b0;
	logic req_valid_i = 1'b0;
	logic req_write_i = 1'b0;
	logic [1:0] req_size_i = 2'h1;
	logic [27:0] req_addr_i = 28'h000_0000;
	logic [31:0] req_wdata_i = 32'h0000_0000;
	logic flash_ready_in_i = 1'b0;
	logic req_ready_o, resp_valid_o, flash_clk_out_o, flash_select_n_o;
	logic addr_valid_n_o, addr_advance_n_o, out_enable_n_o, write_strobe_n_o;
	logic flash_data_oe_o;
	logic [31:0] resp_rdata_o;
	logic [24:0] flash_addr_o;
	logic [15:0] flash_data_o, flash_data_i, mdl_q;
	int err_count = 0;
	int total_checks = 0;
	int cs_cyc = 0;
	int bmem [int];
	logic seen;
	always #12.5 core_clk_i = ~core_clk_i;
	always @(posedge core_clk_i) if (rstn_i && flash_select_n_o !== 1'b1) cs_cyc++;
	// Wire level from whoever drives it
	assign flash_data_i = flash_data_oe_o ? flash_data_o : mdl_q;
	// Flash pins are taken as already routed to this block
	bfa_ctrl bfa_ctrl_i (.core_clk_i, .rstn_i, .op_mode_field_i, .clock_divider_field_i,
		.addr_valid_latency_i, .bus_release_latency_i, .mux_enable_i, .req_valid_i,
		.req_ready_o, .req_write_i, .req_size_i, .req_addr_i, .req_wdata_i, .resp_valid_o,
		.resp_rdata_o, .flash_clk_out_o, .flash_select_n_o, .addr_valid_n_o,
		.addr_advance_n_o, .out_enable_n_o, .write_strobe_n_o, .flash_ready_in_i,
		.flash_addr_o, .flash_data_o, .flash_data_oe_o, .flash_data_i);
	bfa_flash_model bfa_flash_model_i (.clk_i(core_clk_i), .select_n_i(flash_select_n_o),
		.oe_n_i(out_enable_n_o), .we_n_i(write_strobe_n_o), .addr_i(flash_addr_o),
		.data_i(flash_data_i), .data_o(mdl_q));
////////////////////////////////////////
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : tally_and_finish
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value t=%0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask : chk
	task automatic hang(input string m);
		chk(32'h0000_0000, 32'h0000_0001, m);
		tally_and_finish();
	endtask : hang
	function automatic logic [15:0] eh(input int fa);
		return bmem.exists(fa) ? 16'(bmem[fa]) : 16'(fa) ^ 16'h5a3c;
	endfunction : eh
	// One request, taken when ready is seen, checked against the bench model
	task automatic acc(input logic w, input logic [1:0] sz, input logic [27:0] a);
		int i;
		int fa;
		logic [15:0] h;
		logic [31:0] e;
		if (sz != bfa_pkg::SIZE_BYTE)
			a[0] = 1'b0;
		if (sz == bfa_pkg::SIZE_WORD)
			a[1] = 1'b0;
		fa = int'(a[25:1]);
		h = eh(fa);
		cs_cyc = 0;
		req_valid_i = 1'b1;
		req_write_i = w;
		req_size_i = sz;
		req_addr_i = a;
		req_wdata_i = $urandom;
		flash_ready_in_i = 1'($urandom);
		for (i = 0; i < 50 && req_ready_o !== 1'b1; i++) @(negedge core_clk_i);
		if (i == 50)
			hang("request never taken");
		@(negedge core_clk_i);
		req_valid_i = 1'b0;
		for (i = 0; i < 600 && resp_valid_o !== 1'b1; i++) @(negedge core_clk_i);
		if (i == 600)
			hang("no answer");
		if (op_mode_field_i != bfa_pkg::MODE_ASYNC)
			e = 32'h0000_0000;
		else if (sz == bfa_pkg::SIZE_BYTE)
			e = {24'h00_0000, a[0] ? h[15:8] : h[7:0]};
		else if (sz == bfa_pkg::SIZE_WORD)
			e = {eh(fa + 1), h};
		else
			e = {16'h0000, h};
		if (!w && sz == bfa_pkg::SIZE_HALF)
			chk({16'h0000, resp_rdata_o[15:0]}, e, "half read");
		else if (!w)
			chk(resp_rdata_o, e, "read data");
		if (w && sz == bfa_pkg::SIZE_HALF)
			bmem[fa] = int'(req_wdata_i[15:0]);
		else if (w)
			chk(32'(cs_cyc), 32'h0000_0000, "dropped write moved pins");
		// Let an edge pass so the next call never re-raises valid in this time step
		@(negedge core_clk_i);
	endtask : acc
////////////////////////////////////////
	initial begin
		void'($urandom(32'h41df_f063));
		repeat (4) @(negedge core_clk_i);
		rstn_i = 1'b1;
		req_valid_i = 1'b1;
		seen = 1'b0;
		repeat (20) begin
			@(negedge core_clk_i);
			seen = seen | req_ready_o;
		end
		req_valid_i = 1'b0;
		chk({31'h0000_0000, seen}, 32'h0000_0000, "taken while disabled");
		chk(32'(cs_cyc), 32'h0000_0000, "cycles while disabled");
		$display("test disabled done");
		op_mode_field_i = bfa_pkg::MODE_ASYNC;
		for (int d = 0; d < 4; d++) begin
			for (int m = 0; m < 2; m++) begin
				@(negedge core_clk_i);
				clock_divider_field_i = 2'(d);
				mux_enable_i = 1'(m);
				addr_valid_latency_i = 4'($urandom % 4);
				bus_release_latency_i = 2'($urandom % 3 + 1);
				repeat (10) acc(1'($urandom), 2'($urandom % 3), 28'($urandom % 64));
				$display("test divider %0d mux %0d done", d, m);
			end
		end
		for (int m = 2; m < 4; m++) begin
			op_mode_field_i = 2'(m);
			@(negedge core_clk_i);
			acc(1'b0, bfa_pkg::SIZE_HALF, 28'h000_0010);
		end
		op_mode_field_i = bfa_pkg::MODE_ASYNC;
		repeat (2) @(negedge core_clk_i);
		acc(1'b0, bfa_pkg::SIZE_WORD, 28'h000_0020);
		$display("test modes done");
		tally_and_finish();
	end
endmodule : bfa_ctrl_tb_top

// file: sim/bfa_flash_model.sv
// Behavioural 16-bit flash answering asynchronous cycles
`timescale 1ns/1ps
module bfa_flash_model (
	// Clock
	input wire logic clk_i,
	// Flash pins
	input wire logic select_n_i,
	input wire logic oe_n_i,
	input wire logic we_n_i,
	input wire logic [24:0] addr_i,
	input wire logic [15:0] data_i,
	output logic [15:0] data_o
);
	logic [15:0] mem [logic [24:0]];
	logic [15:0] last = 16'h0000;
	function automatic logic [15:0] rd(input logic [24:0] a);
		return mem.exists(a) ? mem[a] : a[15:0] ^ 16'h5a3c;
	endfunction
	always @(posedge clk_i) begin
		if (!select_n_i && !we_n_i)
			mem[addr_i] = data_i;
		if (!select_n_i && !oe_n_i)
			last <= rd(addr_i);
	end
	// Released bus shows the inverse of the last value, never a stale copy
	always @(*) data_o = (!select_n_i && !oe_n_i) ? rd(addr_i) : ~last;
endmodule : bfa_flash_model
